// file: rtl/uhr_pkg.sv
// package for the usb host interrupt and pipe configuration registers
// assumes a single 100 MHz clock domain and synchronous active-high reset
package uhr_pkg;

	// ==========================================================
	// register offsets
	localparam logic [11:0] OFF_ENABLE_CLEAR = 12'h014;
	localparam logic [11:0] OFF_ENABLE_SET = 12'h018;
	localparam logic [11:0] OFF_FLAGS = 12'h01c;
	localparam logic [11:0] OFF_SUMMARY = 12'h020;
	localparam logic [11:0] OFF_STATUS = 12'h024;
	localparam logic [11:0] OFF_PIPE_BASE = 12'h100;
	localparam logic [11:0] PIPE_STRIDE = 12'h020;
	localparam int PIPE_COUNT = 8;
	localparam int PIPE_IDX_W = 3;

	// ==========================================================
	// field layout
	localparam int FLAG_DETACH = 9;
	localparam int FLAG_ATTACH = 8;
	localparam int FLAG_MEM_ERR = 7;
	localparam int FLAG_UP_RESUME = 6;
	localparam int FLAG_DN_RESUME = 5;
	localparam int FLAG_WAKE = 4;
	localparam int FLAG_BUS_RESET = 3;
	localparam int FLAG_FRAME = 2;
	localparam logic [15:0] FLAG_MASK = 16'h03fc;
	localparam logic [7:0] CFG_MASK = 8'h3f;
	localparam int CFG_KIND_LSB = 3;
	localparam int CFG_BANK_BIT = 2;
	localparam logic [15:0] FLAGS_RESET = 16'h0000;
	localparam logic [7:0] CFG_RESET = 8'h00;

	// ==========================================================
	// pipe kinds and tokens
	localparam logic [2:0] KIND_DISABLED = 3'h0;
	localparam logic [2:0] KIND_CONTROL = 3'h1;
	localparam logic [2:0] KIND_ISO = 3'h2;
	localparam logic [2:0] KIND_BULK = 3'h3;
	localparam logic [2:0] KIND_INTERRUPT = 3'h4;
	localparam logic [2:0] KIND_EXTENDED = 3'h5;
	localparam logic [1:0] TOKEN_SETUP = 2'h0;
	localparam logic [1:0] TOKEN_IN = 2'h1;
	localparam logic [1:0] TOKEN_OUT = 2'h2;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic device_detach;
		logic device_attach;
		logic mem_access_error;
		logic upstream_resume_rx;
		logic downstream_resume_tx;
		logic bus_reset_sent;
		logic frame_start_sent;
	} uhr_events_type;

	typedef struct packed {
		logic [1:0] unused;
		logic [2:0] pipe_kind;
		logic bank_count_sel;
		logic [1:0] pipe_token_kind;
	} uhr_pipe_cfg_type;

	typedef struct packed {
		logic enabled;
		logic is_control;
		logic dual_bank;
		logic [1:0] token;
	} uhr_pipe_view_type;

	typedef enum logic [1:0] {
		RD_IDLE = 2'b01,
		RD_DATA = 2'b10
	} uhr_rd_state_type;

endpackage : uhr_pkg

// file: rtl/uhr_cfg_mem.sv
// per-pipe configuration storage, write port and registered read port
// assumes a write in the same cycle as the bus reset strobe may be lost
module uhr_cfg_mem
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic wr_en_in,
	input wire logic [uhr_pkg::PIPE_IDX_W-1:0] wr_idx_in,
	input wire logic [7:0] wr_data_in,
	input wire logic bus_reset_in,
	input wire logic [uhr_pkg::PIPE_IDX_W-1:0] rd_idx_in,
	output logic [7:0] rd_data_out,
	output uhr_pkg::uhr_pipe_cfg_type [uhr_pkg::PIPE_COUNT-1:0] cfg_out
);

	// ==========================================================
	// storage
	logic [7:0] rd_data_reg;
	uhr_pkg::uhr_pipe_cfg_type [uhr_pkg::PIPE_COUNT-1:0] cfg_reg;
	wire uhr_pkg::uhr_pipe_cfg_type [uhr_pkg::PIPE_COUNT-1:0] cfg_next;

	genvar g;
	generate
		for (g = 0; g < uhr_pkg::PIPE_COUNT; g++)
		begin : g_pipe
			wire logic hit = wr_en_in
				&& (wr_idx_in == uhr_pkg::PIPE_IDX_W'(g));
			assign cfg_next[g] = hit
				? uhr_pkg::uhr_pipe_cfg_type'(wr_data_in & uhr_pkg::CFG_MASK)
				: cfg_reg[g];
		end
	endgenerate

	always_ff @(posedge clk_in)
	begin
		if (rst_in || bus_reset_in)
			cfg_reg <= {uhr_pkg::PIPE_COUNT{uhr_pkg::CFG_RESET}};
		else
			cfg_reg <= cfg_next;
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			rd_data_reg <= 8'h00;
		else
			rd_data_reg <= cfg_reg[rd_idx_in];
	end

	assign rd_data_out = rd_data_reg;
	assign cfg_out = cfg_reg;

endmodule : uhr_cfg_mem

// file: rtl/uhr_pipe_decode.sv
// decodes one pipe configuration into what the transaction logic needs
// assumes a registered configuration value at its input
module uhr_pipe_decode
(
	input uhr_pkg::uhr_pipe_cfg_type cfg_in,
	output uhr_pkg::uhr_pipe_view_type view_out
);

	// ==========================================================
	// kind decode
	wire logic kind_valid = (cfg_in.pipe_kind == uhr_pkg::KIND_CONTROL)
		|| (cfg_in.pipe_kind == uhr_pkg::KIND_ISO)
		|| (cfg_in.pipe_kind == uhr_pkg::KIND_BULK)
		|| (cfg_in.pipe_kind == uhr_pkg::KIND_INTERRUPT)
		|| (cfg_in.pipe_kind == uhr_pkg::KIND_EXTENDED);
	wire logic is_ext = cfg_in.pipe_kind == uhr_pkg::KIND_EXTENDED;
	wire logic is_ctl = cfg_in.pipe_kind == uhr_pkg::KIND_CONTROL;
	// setup only on control pipes; token 3 treated as no token
	wire logic tok_ok = (cfg_in.pipe_token_kind == uhr_pkg::TOKEN_IN)
		|| (cfg_in.pipe_token_kind == uhr_pkg::TOKEN_OUT)
		|| (is_ctl && cfg_in.pipe_token_kind == uhr_pkg::TOKEN_SETUP);

	assign view_out.enabled = kind_valid && (is_ext || tok_ok);
	assign view_out.is_control = is_ctl;
	assign view_out.dual_bank = cfg_in.bank_count_sel && !is_ext
		&& !is_ctl;
	assign view_out.token = is_ext ? uhr_pkg::TOKEN_IN
		: cfg_in.pipe_token_kind;

endmodule : uhr_pipe_decode

// file: rtl/uhr_regs.sv
// usb host interrupt enables, flags, pipe summary and pipe configuration
// assumes synchronous event pulses from the host port and pipe engines
// What this block does
// - writing one to enable-set bits 9..2 sets the enable; zero no change
// - reserved bits read zero; software writes them zero
// - detach sets flag bit 9
// - attach sets flag bit 8
// - ram error in an out stage sets flag bit 7
// - received upstream resume sets flag bit 6
// - sent downstream resume sets flag bit 5
// - wake bit 4: resume or detach in suspend, attach with power valid
// - sent bus reset sets flag bit 3
// - each frame start sets bit 2 and updates frame number
// - interrupt request when any enabled flag is set
// - writing one to a flag clears it; zero no effect
// - summary bit n follows pipe n pending; read only
// - pipe kind bits 5:3 decode disabled..extended; 6,7 reserved
// - bus reset clears every pipe kind
// - bank bit 2: zero single bank, one dual bank except on control and extended pipes
// - bus reset clears the bank bit
// - pipe n config at 0x100 plus n times 0x20
// - token bits 1:0 setup, in, out; 3 reserved; cleared on bus reset
// - enable set and clear share one enable store
module uhr_regs
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [11:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [15:0] rdata_out,
	input uhr_pkg::uhr_events_type events_in,
	input wire logic frame_gen_on_in,
	input wire logic bus_power_valid_in,
	input wire logic [10:0] frame_number_in,
	input wire logic [15:0] pipe_irq_pending_in,
	output logic irq_out,
	output logic [10:0] frame_number_out,
	output uhr_pkg::uhr_pipe_view_type [uhr_pkg::PIPE_COUNT-1:0] pipe_view_out
);

	// ==========================================================
	// state
	logic [15:0] enable_reg;
	logic [15:0] enable_next;
	logic [15:0] flags_reg;
	logic [15:0] flags_next;
	logic [10:0] frame_number_reg;
	logic [15:0] rdata_reg;
	logic [15:0] rdata_next;
	logic cfg_sel_reg;
	uhr_pkg::uhr_rd_state_type rd_state_reg;
	uhr_pkg::uhr_rd_state_type rd_state_next;
	wire logic [7:0] cfg_rdata;
	uhr_pkg::uhr_pipe_cfg_type [uhr_pkg::PIPE_COUNT-1:0] cfg_all;

	// ==========================================================
	// address decode
	wire logic hit_en_clr = addr_in == uhr_pkg::OFF_ENABLE_CLEAR;
	wire logic hit_en_set = addr_in == uhr_pkg::OFF_ENABLE_SET;
	wire logic hit_flags = addr_in == uhr_pkg::OFF_FLAGS;
	wire logic hit_summary = addr_in == uhr_pkg::OFF_SUMMARY;
	wire logic hit_status = addr_in == uhr_pkg::OFF_STATUS;
	wire logic [11:0] pipe_rel = addr_in - uhr_pkg::OFF_PIPE_BASE;
	wire logic hit_pipe = (addr_in >= uhr_pkg::OFF_PIPE_BASE)
		&& (pipe_rel[4:0] == 5'h00)
		&& (pipe_rel[11:5] < 7'(uhr_pkg::PIPE_COUNT));
	wire logic [uhr_pkg::PIPE_IDX_W-1:0] pipe_idx =
		pipe_rel[5 +: uhr_pkg::PIPE_IDX_W];
	wire logic wr_data_en = wr_in && hit_pipe;

	// ==========================================================
	// event sources
	wire logic [15:0] ev_base = {6'h00,
		events_in.device_detach,
		events_in.device_attach,
		events_in.mem_access_error,
		events_in.upstream_resume_rx,
		events_in.downstream_resume_tx,
		1'b0,
		events_in.bus_reset_sent,
		events_in.frame_start_sent,
		2'h0};
	wire logic wake_ev = (!frame_gen_on_in && events_in.upstream_resume_rx)
		|| (!frame_gen_on_in && events_in.device_detach)
		|| (bus_power_valid_in && events_in.device_attach);
	wire logic [15:0] ev_set = ev_base
		| (16'(wake_ev) << uhr_pkg::FLAG_WAKE);

	// ==========================================================
	// flag and enable next values
	wire logic [15:0] flag_clr = (wr_in && hit_flags) ? wdata_in
		: 16'h0000;
	wire logic [15:0] en_set = (wr_in && hit_en_set) ? wdata_in
		: 16'h0000;
	wire logic [15:0] en_clr = (wr_in && hit_en_clr) ? wdata_in
		: 16'h0000;
	// set wins over a clear in the same cycle
	assign flags_next = ((flags_reg & ~flag_clr) | ev_set)
		& uhr_pkg::FLAG_MASK;
	assign enable_next = ((enable_reg & ~en_clr) | en_set)
		& uhr_pkg::FLAG_MASK;

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			flags_reg <= uhr_pkg::FLAGS_RESET;
			enable_reg <= uhr_pkg::FLAGS_RESET;
		end
		else
		begin
			flags_reg <= flags_next;
			enable_reg <= enable_next;
		end
	end

	assign irq_out = |(flags_reg & enable_reg);

	// ==========================================================
	// frame number captured with each frame start
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			frame_number_reg <= 11'h000;
		else if (events_in.frame_start_sent)
			frame_number_reg <= frame_number_in;
	end

	assign frame_number_out = frame_number_reg;

	// ==========================================================
	// pipe configuration store and decode
	uhr_cfg_mem uhr_cfg_mem_i
	(
		.clk_in(clk_in),
		.rst_in(rst_in),
		.wr_en_in(wr_data_en),
		.wr_idx_in(pipe_idx),
		.wr_data_in(wdata_in[7:0]),
		.bus_reset_in(events_in.bus_reset_sent),
		.rd_idx_in(pipe_idx),
		.rd_data_out(cfg_rdata),
		.cfg_out(cfg_all)
	);

	genvar g;
	generate
		for (g = 0; g < uhr_pkg::PIPE_COUNT; g++)
		begin : g_view
			uhr_pipe_decode uhr_pipe_decode_i
			(
				.cfg_in(cfg_all[g]),
				.view_out(pipe_view_out[g])
			);
		end
	endgenerate

	// ==========================================================
	// read path
	wire logic [15:0] status_word = {13'h0000, bus_power_valid_in,
		frame_gen_on_in, irq_out};
	always_comb
	begin
		rdata_next = 16'h0000;
		if (rd_in)
		begin
			if (hit_en_clr || hit_en_set)
				rdata_next = enable_reg;
			else if (hit_flags)
				rdata_next = flags_reg;
			else if (hit_summary)
				rdata_next = pipe_irq_pending_in;
			else if (hit_status)
				rdata_next = status_word;
		end
	end

	assign rd_state_next = rd_in ? uhr_pkg::RD_DATA : uhr_pkg::RD_IDLE;

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			rdata_reg <= 16'h0000;
			cfg_sel_reg <= 1'b0;
			rd_state_reg <= uhr_pkg::RD_IDLE;
		end
		else
		begin
			rdata_reg <= rdata_next;
			cfg_sel_reg <= rd_in && hit_pipe;
			rd_state_reg <= rd_state_next;
		end
	end

	always_comb
	begin
		unique case (rd_state_reg)
			uhr_pkg::RD_DATA:
				rdata_out = cfg_sel_reg ? {8'h00, cfg_rdata} : rdata_reg;
			uhr_pkg::RD_IDLE:
				rdata_out = 16'h0000;
			default:
				rdata_out = 16'h0000;
		endcase
	end

endmodule : uhr_regs

// file: tb/uhr_regs_chk.sv
// checker for the usb host register block
// assumes a bind onto every uhr_regs instance
module uhr_regs_chk
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [11:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [15:0] rdata_out,
	input uhr_pkg::uhr_events_type events_in,
	input wire logic bus_power_valid_in,
	input wire logic [10:0] frame_number_in,
	input wire logic [15:0] pipe_irq_pending_in,
	input wire logic irq_out,
	input wire logic [10:0] frame_number_out,
	input uhr_pkg::uhr_pipe_view_type [7:0] pipe_view_out
);
	// ==========
	// helpers
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	logic any_en;
	wire rd_flags = rd_in && addr_in == uhr_pkg::OFF_FLAGS;
	always_comb
	begin
		any_en = 1'b0;
		for (int i = 0; i < 8; i++)
			any_en = any_en | pipe_view_out[i].enabled;
	end
	sequence s_attach_read;
		events_in.device_attach && bus_power_valid_in ##2 rd_flags;
	endsequence
	sequence s_clear_read;
		wr_in && addr_in == uhr_pkg::OFF_FLAGS && wdata_in == 16'h03fc
			&& events_in == '0 ##1 events_in == '0 ##1 rd_flags;
	endsequence
	// ==========
	// properties
	property p_flag_rsvd;
		rd_flags |=> rdata_out[15:10] == 6'h00 && rdata_out[1:0] == 2'h0;
	endproperty
	a_flag_rsvd: assert property (p_flag_rsvd) else $error("flag rsvd");
	property p_cfg_rsvd;
		rd_in && addr_in >= uhr_pkg::OFF_PIPE_BASE |=> rdata_out[15:6] == 10'h000;
	endproperty
	a_cfg_rsvd: assert property (p_cfg_rsvd) else $error("cfg rsvd");
	property p_summary;
		rd_in && addr_in == uhr_pkg::OFF_SUMMARY
			|=> rdata_out == $past(pipe_irq_pending_in);
	endproperty
	a_summary: assert property (p_summary) else $error("summary");
	property p_frame;
		events_in.frame_start_sent |=> frame_number_out == $past(frame_number_in);
	endproperty
	a_frame: assert property (p_frame) else $error("frame number");
	property p_irq;
		wr_in && addr_in == uhr_pkg::OFF_ENABLE_SET && wdata_in[2]
			##2 events_in.frame_start_sent |=> irq_out;
	endproperty
	a_irq: assert property (p_irq) else $error("irq");
	property p_attach;
		s_attach_read |=> rdata_out[8];
	endproperty
	a_attach: assert property (p_attach) else $error("attach");
	property p_wake;
		s_attach_read |=> rdata_out[4];
	endproperty
	a_wake: assert property (p_wake) else $error("wake");
	property p_clear;
		s_clear_read |=> rdata_out == 16'h0000;
	endproperty
	a_clear: assert property (p_clear) else $error("clear");
	property p_bus_reset;
		events_in.bus_reset_sent |=> !any_en;
	endproperty
	a_bus_reset: assert property (p_bus_reset) else $error("cfg kept");
endmodule : uhr_regs_chk

bind uhr_regs uhr_regs_chk uhr_regs_chk_i (.clk_in(clk_in), .rst_in(rst_in),
	.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
	.rdata_out(rdata_out), .events_in(events_in),
	.bus_power_valid_in(bus_power_valid_in),
	.frame_number_in(frame_number_in), .irq_out(irq_out),
	.pipe_irq_pending_in(pipe_irq_pending_in),
	.frame_number_out(frame_number_out), .pipe_view_out(pipe_view_out));

// file: tb/uhr_usb_dev.sv
// model of the usb device on the host port
// assumes one register clock; bit 2 detach, 1 attach, 0 resume
module uhr_usb_dev
(
	input wire logic clk_in,
	output logic [2:0] ev_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial ev_out = 3'h0;
	task automatic send(input int k);
		@(posedge clk_in);
		ev_out[k] <= 1'b1;
		@(posedge clk_in);
		ev_out[k] <= 1'b0;
	endtask : send
endmodule : uhr_usb_dev

// file: tb/uhr_regs_test.sv
// self-checking bench for the usb host register block
// assumes the usb device model and the bound checker
module uhr_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in, rst_in, wr, rd, fg, pv, irq;
	logic [11:0] addr;
	logic [15:0] wdata, rdata, pend;
	logic [3:0] host;
	logic [2:0] dev;
	logic [10:0] fn_in, fn_out;
	uhr_pkg::uhr_events_type ev;
	uhr_pkg::uhr_pipe_view_type [7:0] view;
	int n_fail = 0;
	int samples_checked = 0;
	localparam int FB[7] = '{2, 3, 5, 6, 7, 8, 9};
	assign ev = uhr_pkg::uhr_events_type'({dev[2:1], host[3], dev[0],
		host[2:0]});
	uhr_regs uhr_regs_i (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr),
		.wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
		.events_in(ev), .frame_gen_on_in(fg), .bus_power_valid_in(pv),
		.frame_number_in(fn_in), .pipe_irq_pending_in(pend), .irq_out(irq),
		.frame_number_out(fn_out), .pipe_view_out(view));
	uhr_usb_dev uhr_usb_dev_i (.clk_in(clk_in), .ev_out(dev));
	// ==========
	// bus and compare tasks
	task automatic chk(input string s, input logic [15:0] e,
		input logic [15:0] g);
		samples_checked++;
		if (g !== e)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic wr_reg(input logic [11:0] a, input logic [15:0] d);
		@(posedge clk_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_in);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_chk(input string s, input logic [11:0] a,
		input logic [15:0] e);
		@(posedge clk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_in);
		rd <= 1'b0;
		#1;
		chk(s, e, rdata);
	endtask : rd_chk
	task automatic pulse(input int k);
		if (k == 3 || k > 4)
			uhr_usb_dev_i.send(k == 3 ? 0 : k - 4);
		else
		begin
			@(posedge clk_in);
			host[k == 4 ? 3 : k] <= 1'b1;
			@(posedge clk_in);
			host <= 4'h0;
		end
	endtask : pulse
	task automatic ev_chk(input int k, input logic [15:0] e);
		pulse(k);
		rd_chk("flags", uhr_pkg::OFF_FLAGS, e);
		wr_reg(uhr_pkg::OFF_FLAGS, uhr_pkg::FLAG_MASK);
		rd_chk("flags", uhr_pkg::OFF_FLAGS, 16'h0000);
	endtask : ev_chk
	function automatic logic [11:0] pa(input int n);
		return 12'(uhr_pkg::OFF_PIPE_BASE + uhr_pkg::PIPE_STRIDE * n);
	endfunction : pa
	// ==========
	// scenarios
	task automatic t_enable;
		wr_reg(uhr_pkg::OFF_ENABLE_SET, 16'hffff);
		rd_chk("en", uhr_pkg::OFF_ENABLE_SET, 16'h03fc);
		wr_reg(uhr_pkg::OFF_ENABLE_CLEAR, 16'h0204);
		wr_reg(uhr_pkg::OFF_ENABLE_SET, 16'h0000);
		rd_chk("en", uhr_pkg::OFF_ENABLE_SET, 16'h01f8);
		wr_reg(uhr_pkg::OFF_ENABLE_CLEAR, 16'hffff);
		rd_chk("en", uhr_pkg::OFF_ENABLE_CLEAR, 16'h0000);
	endtask : t_enable
	task automatic t_events;
		for (int k = 0; k < 7; k++)
			ev_chk(k, 16'h0001 << FB[k]);
		@(posedge clk_in);
		fg <= 1'b0;
		ev_chk(3, 16'h0050);
		ev_chk(6, 16'h0210);
		@(posedge clk_in);
		fg <= 1'b1;
		pv <= 1'b1;
		pulse(5);
		wr_reg(uhr_pkg::OFF_FLAGS, 16'h0000);
		rd_chk("flags", uhr_pkg::OFF_FLAGS, 16'h0110);
		ev_chk(5, 16'h0110);
	endtask : t_events
	task automatic t_irq;
		wr_reg(uhr_pkg::OFF_ENABLE_SET, 16'h0004);
		fn_in <= 11'h35a;
		pulse(0);
		#1;
		chk("irq", 16'h0001, 16'(irq));
		chk("frame_number", 16'h035a, 16'(fn_out));
		wr_reg(uhr_pkg::OFF_ENABLE_CLEAR, 16'h0004);
		#1;
		chk("irq", 16'h0000, 16'(irq));
		wr_reg(uhr_pkg::OFF_ENABLE_SET, 16'h0004);
		wr_reg(uhr_pkg::OFF_FLAGS, 16'h0004);
		#1;
		chk("irq", 16'h0000, 16'(irq));
	endtask : t_irq
	task automatic t_summary;
		wr_reg(uhr_pkg::OFF_SUMMARY, 16'h0000);
		rd_chk("sum", uhr_pkg::OFF_SUMMARY, 16'ha5c3);
		@(posedge clk_in);
		pend <= 16'h0000;
		rd_chk("sum", uhr_pkg::OFF_SUMMARY, 16'h0000);
		rd_chk("unmapped", 12'h0f0, 16'h0000);
		rd_chk("status", uhr_pkg::OFF_STATUS, 16'h0006);
	endtask : t_summary
	task automatic t_pipes;
		logic [15:0] d;
		for (int n = 0; n < 8; n++)
		begin
			d = 16'(8'hc1 | (n == 1 ? 0 : 4) | n << 3);
			wr_reg(pa(n), d);
			rd_chk("cfg", pa(n), d & 16'h003f);
			chk("pen", 16'(n > 0 && n < 6), 16'(view[n].enabled));
		end
		chk("bank", 16'h0001, 16'(view[3].dual_bank));
		chk("bank", 16'h0000, 16'(view[1].dual_bank));
		chk("ctl", 16'h0001, 16'(view[1].is_control));
		wr_reg(pa(1), 16'h0008);
		wr_reg(pa(2), 16'h0013);
		#1;
		chk("pen", 16'h0001, 16'(view[1].enabled));
		chk("pen", 16'h0000, 16'(view[2].enabled));
		pulse(1);
		for (int n = 0; n < 8; n++)
			rd_chk("cfg", pa(n), 16'h0000);
	endtask : t_pipes
	task automatic report_and_stop;
		if (n_fail == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop
	// ==========
	// clock, reset, sequence, watchdog
	initial
	begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	initial
	begin
		{rst_in, fg, pv, wr, rd, addr, wdata, host} = {3'b110, 34'h0};
		fn_in = 11'h5a5;
		pend = 16'ha5c3;
		repeat (20) @(posedge clk_in);
		rst_in <= 1'b0;
		t_enable;
		t_events;
		t_irq;
		t_summary;
		t_pipes;
		report_and_stop;
	end
	initial
	begin
		#20000;
		n_fail++;
		report_and_stop;
	end
endmodule : uhr_regs_test
